// File: hdl/vxc_crosspoint_ctrl.sv
// Functional notes
// - route code selects the matching input
// - index one: bits 7..4 gain, clear gives two
// - bits 3,2 clamp inputs one, zero when clear
// - bits 1,0 drive the two aux outputs
// - index two: bits 3..0 enable outputs
// - reset: high-z, input zero, gain two, inputs zero, one clamped
// - all straps high: ignore bus, pin mode
// - pin mode: gain two, all clamped, all active
// - pin mode route is output XOR scl,sda
// - scl swaps pairs, sda swaps neighbours
// - index zero: two route bits per output
// - index increments per byte, wraps after two
// - both aux outputs low after power-up
// - straps give three low address bits
`timescale 1ns/1ps

`include "vxc_cfg.svh"

module vxc_crosspoint_ctrl (
	// clock and power-on reset
	input  wire logic             clk,
	input  wire logic             reset,
	// serial control pins; sda is open drain
	input  wire logic             sclPin,
	input  wire logic             sdaIn,
	output logic                  sdaOut,
	output logic                  sdaOeN,
	// address straps
	input  wire logic             addrStrapZero,
	input  wire logic             addrStrapOne,
	input  wire logic             addrStrapTwo,
	// route codes for video drives 0..3
	output vxc_pkg::vxc_code_t    routeCode0,
	output vxc_pkg::vxc_code_t    routeCode1,
	output vxc_pkg::vxc_code_t    routeCode2,
	output vxc_pkg::vxc_code_t    routeCode3,
	// analog path controls
	output logic [3:0]            gainSelectBit,
	output logic [3:0]            clampEnable,
	output logic [3:0]            driveEnableBit,
	// open-drain aux logic outputs
	output logic                  auxLogicOutZero,
	output logic                  auxLogicOutZeroOeN,
	output logic                  auxLogicOutOne,
	output logic                  auxLogicOutOneOeN
);
	import vxc_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		vxc_bus_t        state;       // receive sequencer
		logic [3:0]      bitCnt;      // bits taken of current byte
		logic [7:0]      shift;       // byte being received
		logic [1:0]      idx;         // function index
		logic            ackDrive;    // pulling sda low
		logic            sclPrev;     // synced scl, one cycle ago
		logic            sdaPrev;     // synced sda, one cycle ago
		logic [7:0]      routeByte;   // route select byte
		logic [7:0]      gainByte;    // gain, clamp and aux byte
		logic [7:0]      enableByte;  // output drive enable byte
		logic [1:0]      strapWait;   // cycles since reset release
		logic            strapDone;   // straps captured
		logic            pinMode;     // pin-controlled mode
		logic [2:0]      devAddr;     // low address bits from straps
		logic [3:0][1:0] outRoute;    // registered route codes
		logic [3:0]      outGain;     // registered gain selects
		logic [3:0]      outClamp;    // registered clamp enables
		logic [3:0]      outDrive;    // registered drive enables
		logic [1:0]      outAux;      // registered aux levels
	} vxc_core_t;

	vxc_core_t q;       // registered state
	vxc_core_t next_q;  // next state

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [4:0] syncLevel;  // {strap2, strap1, strap0, sda, scl}
	logic       scl;        // synced scl
	logic       sda;        // synced sda
	logic [2:0] strap;      // synced straps

	vxc_sync #(
		.WIDTH(5)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.pinLevel ({addrStrapTwo, addrStrapOne, addrStrapZero, sdaIn, sclPin}),
		.syncLevel(syncLevel)
	);

	assign scl   = syncLevel[0];
	assign sda   = syncLevel[1];
	assign strap = syncLevel[4:2];

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// route code of output j from the route select byte
	function automatic logic [1:0] routeOf(input logic [7:0] rb, input int j);
		routeOf = rb[2*j +: 2];
	endfunction : routeOf

	// next function index, wrapping after the third register
	function automatic logic [1:0] nextIdx(input logic [1:0] cur);
		nextIdx = (cur >= `VXC_IDX_ENABLE) ? `VXC_IDX_ROUTE : cur + 2'h1;
	endfunction : nextIdx

	// ---------------------------------------------------------------
	// bus events
	// ---------------------------------------------------------------
	logic busActive;  // bus mode and straps known
	logic sclRise;    // scl rising edge
	logic sclFall;    // scl falling edge
	logic startCond;  // sda falls while scl high
	logic stopCond;   // sda rises while scl high
	logic byteDone;   // eighth bit taken, scl falling
	logic commitNow;  // data byte acknowledged, write it

	// edges look only at the second sync stage and its delayed copy
	assign busActive = q.strapDone & ~q.pinMode;
	assign sclRise   = scl & ~q.sclPrev;
	assign sclFall   = ~scl & q.sclPrev;
	assign startCond = scl & q.sclPrev & q.sdaPrev & ~sda;
	assign stopCond  = scl & q.sclPrev & ~q.sdaPrev & sda;
	assign byteDone  = sclFall & (q.bitCnt == `VXC_BYTE_BITS);
	assign commitNow = busActive & ~startCond & ~stopCond & sclFall
		& (q.state == BUS_DATA_ACK);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_q         = q;
		next_q.sclPrev = scl;
		next_q.sdaPrev = sda;

		// straps are caught a few cycles after release, once synced
		if (!q.strapDone) begin
			next_q.strapWait = q.strapWait + 2'h1;
			if (q.strapWait == `VXC_STRAP_WAIT) begin
				next_q.strapDone = 1'b1;
				next_q.pinMode   = (strap == `VXC_STRAP_PINMODE);
				next_q.devAddr   = strap;
			end
		end

		// receive sequencer; pin mode leaves it parked and silent
		if (!busActive) begin
			next_q.state    = BUS_IDLE;
			next_q.ackDrive = 1'b0;
		end else if (startCond) begin
			// a repeated start restarts the address phase
			next_q.state    = BUS_ADDR;
			next_q.bitCnt   = 4'h0;
			next_q.ackDrive = 1'b0;
		end else if (stopCond) begin
			next_q.state    = BUS_IDLE;
			next_q.ackDrive = 1'b0;
		end else begin
			case (q.state)
				// shift in bits on rising scl
				BUS_ADDR, BUS_SUB, BUS_DATA: begin
					if (sclRise) begin
						next_q.shift  = {q.shift[6:0], sda};
						next_q.bitCnt = q.bitCnt + 4'h1;
					end else if (byteDone) begin
						next_q.bitCnt = 4'h0;
						if (q.state == BUS_ADDR) begin
							// only our write address is acknowledged
							if (q.shift == {`VXC_ADDR_HIGH, q.devAddr, `VXC_RW_WRITE}) begin
								next_q.ackDrive = 1'b1;
								next_q.state    = BUS_ADDR_ACK;
							end else begin
								next_q.state = BUS_IDLE;
							end
						end else if (q.state == BUS_SUB) begin
							// upper index bits are don't care
							next_q.idx      = q.shift[1:0];
							next_q.ackDrive = 1'b1;
							next_q.state    = BUS_SUB_ACK;
						end else begin
							next_q.ackDrive = 1'b1;
							next_q.state    = BUS_DATA_ACK;
						end
					end
				end
				// release sda when the ack clock ends
				BUS_ADDR_ACK: begin
					if (sclFall) begin
						next_q.ackDrive = 1'b0;
						next_q.state    = BUS_SUB;
					end
				end
				BUS_SUB_ACK: begin
					if (sclFall) begin
						next_q.ackDrive = 1'b0;
						next_q.state    = BUS_DATA;
					end
				end
				BUS_DATA_ACK: begin
					if (sclFall) begin
						next_q.ackDrive = 1'b0;
						next_q.state    = BUS_DATA;
					end
				end
				// idle waits for a start
				default: begin
					next_q.state    = BUS_IDLE;
					next_q.ackDrive = 1'b0;
				end
			endcase
		end

		// write only after the ack clock, so a stop mid-ack drops the byte
		if (commitNow) begin
			case (q.idx)
				`VXC_IDX_ROUTE:  next_q.routeByte  = q.shift;
				`VXC_IDX_GAIN:   next_q.gainByte   = q.shift;
				`VXC_IDX_ENABLE: next_q.enableByte = q.shift;
				default:         next_q.routeByte  = q.routeByte;
			endcase
			next_q.idx = nextIdx(q.idx);
		end

		// outputs follow the stored bytes or the pin levels
		if (q.pinMode) begin
			for (int j = 0; j < 4; j++) begin
				next_q.outRoute[j] = 2'(j) ^ {scl, sda};
			end
			next_q.outGain  = 4'h0;
			next_q.outClamp = 4'hf;
			next_q.outDrive = 4'hf;
			next_q.outAux   = 2'h0;
		end else begin
			for (int j = 0; j < 4; j++) begin
				next_q.outRoute[j] = routeOf(next_q.routeByte, j);
			end
			next_q.outGain  = next_q.gainByte[`VXC_GAIN_MSB:`VXC_GAIN_LSB];
			// inputs two and three have no clamp control on the bus
			next_q.outClamp = {2'h0, ~next_q.gainByte[`VXC_CLAMP_MSB:`VXC_CLAMP_LSB]};
			next_q.outDrive = next_q.enableByte[`VXC_ENABLE_MSB:0];
			next_q.outAux   = next_q.gainByte[`VXC_AUX_ONE:`VXC_AUX_ZERO];
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			q            <= '0;
			q.state      <= BUS_IDLE;
			q.routeByte  <= `VXC_RST_ROUTE;
			q.gainByte   <= `VXC_RST_GAIN;
			q.enableByte <= `VXC_RST_ENABLE;
			// registered clamps must match the reset byte, or they read all off for one cycle
			q.outClamp   <= `VXC_RST_CLAMP;
		end else begin
			q <= next_q;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign sdaOut             = 1'b0;
	assign sdaOeN             = ~q.ackDrive;
	assign routeCode0         = q.outRoute[0];
	assign routeCode1         = q.outRoute[1];
	assign routeCode2         = q.outRoute[2];
	assign routeCode3         = q.outRoute[3];
	assign gainSelectBit      = q.outGain;
	assign clampEnable        = q.outClamp;
	assign driveEnableBit     = q.outDrive;
	// a set aux bit releases the line, a clear one pulls it low
	assign auxLogicOutZero    = 1'b0;
	assign auxLogicOutZeroOeN = q.outAux[0];
	assign auxLogicOutOne     = 1'b0;
	assign auxLogicOutOneOeN  = q.outAux[1];

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	logic busMode;  // helper: bus mode settled
	assign busMode = q.strapDone & ~q.pinMode;

	AST_ROUTE_FROM_CODE: assert property (
		busMode |-> routeCode3 == q.routeByte[7:6] && routeCode0 == q.routeByte[1:0])
		else $error("route code differs from route byte");
	AST_GAIN_BITS: assert property (
		busMode |-> gainSelectBit == q.gainByte[7:4])
		else $error("gain selects differ from control byte");
	AST_CLAMP_BITS: assert property (
		busMode |-> clampEnable == {2'h0, ~q.gainByte[3:2]})
		else $error("clamp enables differ from control byte");
	AST_AUX_LEVELS: assert property (
		busMode |-> auxLogicOutOneOeN == q.gainByte[1] && auxLogicOutZeroOeN == q.gainByte[0])
		else $error("aux outputs differ from control byte");
	AST_DRIVE_EN: assert property (
		busMode |-> driveEnableBit == q.enableByte[3:0])
		else $error("drive enables differ from enable byte");
	AST_RESET_DEFAULTS: assert property (
		$past(reset) |-> driveEnableBit == 4'h0 && routeCode2 == 2'h0
			&& gainSelectBit == 4'h0 && clampEnable[1:0] == 2'h3 && !auxLogicOutOneOeN)
		else $error("wrong state after reset");
	AST_PIN_SILENT: assert property (
		q.pinMode |-> sdaOeN)
		else $error("sda driven in pin mode");
	AST_PIN_STATIC: assert property (
		q.pinMode |=> gainSelectBit == 4'h0 && clampEnable == 4'hf && driveEnableBit == 4'hf)
		else $error("pin mode controls wrong");
	AST_PIN_ROUTE: assert property (
		q.pinMode |=> routeCode1 == (2'h1 ^ {$past(scl), $past(sda)})
			&& routeCode3 == (2'h3 ^ {$past(scl), $past(sda)}))
		else $error("pin mode route wrong");
	AST_INDEX_WRAP: assert property (
		commitNow && q.idx == `VXC_IDX_ENABLE |=> q.idx == `VXC_IDX_ROUTE)
		else $error("function index did not wrap");
	AST_ADDR_ACK: assert property (
		busActive && !startCond && !stopCond && q.state == BUS_ADDR && byteDone
			&& q.shift == {`VXC_ADDR_HIGH, q.devAddr, 1'b0} |=> !sdaOeN)
		else $error("own address not acknowledged");
	AST_COMMIT_APPLY: assert property (
		commitNow && q.idx == `VXC_IDX_ENABLE |=> ##1 driveEnableBit == $past(q.shift[3:0], 2))
		else $error("enable byte not applied");

	COV_ROUTE_WRITE: cover property (commitNow && q.idx == `VXC_IDX_ROUTE);
	COV_WRAP_WRITE: cover property (commitNow && q.idx == `VXC_IDX_ENABLE ##[1:400] commitNow);
	COV_PIN_MODE: cover property (q.pinMode && scl && sda);

endmodule : vxc_crosspoint_ctrl

// File: common/vxc_cfg.svh
`ifndef VXC_CFG_SVH
`define VXC_CFG_SVH

// ---------------------------------------------------------------
// bus addressing
// ---------------------------------------------------------------
`define VXC_ADDR_HIGH      4'h9   // fixed upper four bits of the seven-bit address
`define VXC_RW_WRITE       1'b0   // only writes are accepted
`define VXC_STRAP_PINMODE  3'h7   // all straps high selects pin-controlled mode

// ---------------------------------------------------------------
// function indices
// ---------------------------------------------------------------
`define VXC_IDX_ROUTE      2'h0   // route select byte
`define VXC_IDX_GAIN       2'h1   // gain, clamp and aux byte
`define VXC_IDX_ENABLE     2'h2   // output drive enable byte

// ---------------------------------------------------------------
// field positions of the gain, clamp and aux byte and the enable byte
// ---------------------------------------------------------------
`define VXC_GAIN_MSB       7
`define VXC_GAIN_LSB       4
`define VXC_CLAMP_MSB      3      // clamp off, input one
`define VXC_CLAMP_LSB      2      // clamp off, input zero
`define VXC_AUX_ONE        1
`define VXC_AUX_ZERO       0
`define VXC_ENABLE_MSB     3

// ---------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------
`define VXC_RST_ROUTE      8'h00  // every output on input zero
`define VXC_RST_GAIN       8'h00  // gain two, clamps on, aux low
`define VXC_RST_ENABLE     8'h00  // every output high impedance
`define VXC_RST_CLAMP      4'h3   // inputs zero and one clamped, as the reset gain byte implies
`define VXC_BYTE_BITS      4'h8   // bits per received byte
`define VXC_STRAP_WAIT     2'h3   // cycles after reset before straps are trusted

`endif

// File: common/vxc_pkg.sv
// ---------------------------------------------------------------
// shared types of the crosspoint control
// ---------------------------------------------------------------
package vxc_pkg;

	// route code of one output, the index of its source input
	typedef logic [1:0] vxc_code_t;

	// receive sequencer of the serial control port
	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ADDR_ACK,
		BUS_SUB,
		BUS_SUB_ACK,
		BUS_DATA,
		BUS_DATA_ACK
	} vxc_bus_t;

endpackage : vxc_pkg

// File: hdl/vxc_sync.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// two-stage synchroniser for pin levels
// ---------------------------------------------------------------
module vxc_sync #(
	parameter int WIDTH = 5
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] pinLevel,
	output logic      [WIDTH-1:0] syncLevel
);

	// first stage feeds only the second stage
	typedef struct packed {
		logic [WIDTH-1:0] stageOne;
		logic [WIDTH-1:0] stageTwo;
	} vxc_sync_t;

	vxc_sync_t q;       // registered state
	vxc_sync_t next_q;  // next state

	// shift the levels one stage along
	always_comb begin
		next_q.stageOne = pinLevel;
		next_q.stageTwo = q.stageOne;
	end

	// register the state
	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign syncLevel = q.stageTwo;

endmodule : vxc_sync

// File: test/vxc_bus_master.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// behavioural serial control master at the far side of the block
// ---------------------------------------------------------------
module vxc_bus_master (
	// pacing clock
	input  wire logic clk,
	// resolved data line, pull-up included
	input  wire logic sdaLine,
	// line drives, high means released
	output logic      sclDrive,
	output logic      sdaDrive
);
	// lines idle released, so the clock stands still high between frames
	initial begin
		sclDrive = 1'b1;
		sdaDrive = 1'b1;
	end

	// step n edges, then move just off the edge like every other driver
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// one bit cell of 8 cycles: data set mid-low, held through the high phase
	task automatic bit_cell(input logic b, output logic seen);
		tick(2);
		sdaDrive = b;
		tick(2);
		sclDrive = 1'b1;
		tick(2);
		seen = sdaLine;
		tick(2);
		sclDrive = 1'b0;
	endtask : bit_cell

	// start, n bytes msb first each with an ack cell, stop; byte i ack in acked[i]
	task automatic xfer(input logic [47:0] seq, input int n, output logic [5:0] acked);
		logic s;
		acked = 6'h00;
		sdaDrive = 1'b0;
		tick(4);
		sclDrive = 1'b0;
		for (int i = 0; i < n; i++) begin
			for (int k = 7; k >= 0; k--) bit_cell(seq[40-8*i+k], s);
			bit_cell(1'b1, s);
			acked[i] = ~s;
		end
		// stop: data rises while the clock is high
		tick(2);
		sdaDrive = 1'b0;
		tick(2);
		sclDrive = 1'b1;
		tick(2);
		sdaDrive = 1'b1;
		tick(4);
	endtask : xfer

	// static levels for pin-controlled mode, clock level on top
	task automatic set_levels(input logic [1:0] lv);
		{sclDrive, sdaDrive} = lv;
	endtask : set_levels
endmodule : vxc_bus_master

// File: test/test_video_crosspoint_control.sv
`timescale 1ns/1ps

`include "vxc_cfg.svh"

module test_video_crosspoint_control;
	import vxc_pkg::*;
	// ---------------------------------------------------------------
	// signals and expected snapshot
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] route;   // output 3 in the top pair
		logic [3:0] gain;    // set bit: gain one
		logic [3:0] clamp;   // set bit: input clamped
		logic [3:0] drive;   // set bit: output active
		logic [1:0] aux;     // line levels with pull-ups
	} vxc_note_t;

	logic         clk;
	logic         reset;
	logic [2:0]   strap;
	logic [7:0]   good;      // own address byte, write
	wire          sclDrive;
	wire          sdaDrive;
	wire          sdaOut;
	wire          sdaOeN;
	wire          sdaLine;
	vxc_code_t    rc0, rc1, rc2, rc3;
	wire [3:0]    gainSel, clampEn, driveEn;
	wire          auxZ, auxZOeN, auxO, auxOOeN;
	vxc_note_t    model;     // running expectation
	vxc_note_t    notes[$];  // expectations waiting for the monitor
	vxc_note_t    e;
	event         resultReady;
	int           failures = 0;
	int           checks = 0;

	// open drain: anyone enabled pulls low, pull-up otherwise
	assign sdaLine = sdaDrive & (sdaOeN | sdaOut);

	vxc_bus_master bfm (.clk(clk), .sdaLine(sdaLine), .sclDrive(sclDrive), .sdaDrive(sdaDrive));

	vxc_crosspoint_ctrl dut (
		.clk(clk), .reset(reset), .sclPin(sclDrive), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOeN(sdaOeN), .addrStrapZero(strap[0]),
		.addrStrapOne(strap[1]), .addrStrapTwo(strap[2]),
		.routeCode0(rc0), .routeCode1(rc1), .routeCode2(rc2), .routeCode3(rc3),
		.gainSelectBit(gainSel), .clampEnable(clampEn), .driveEnableBit(driveEn),
		.auxLogicOutZero(auxZ), .auxLogicOutZeroOeN(auxZOeN),
		.auxLogicOutOne(auxO), .auxLogicOutOneOeN(auxOOeN));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// checking helpers
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		if (failures == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict

	// monitor: oldest note against the outputs whenever a result is ready
	initial forever begin
		@(resultReady);
		e = notes.pop_front();
		check("route", {rc3, rc2, rc1, rc0}, e.route);
		check("gain", gainSel, e.gain);
		check("clamp", clampEn, e.clamp);
		check("drive", driveEn, e.drive);
		check("aux", {auxOOeN ? 1'b1 : auxO, auxZOeN ? 1'b1 : auxZ}, e.aux);
	end

	// register byte effect, as the model sees it
	function automatic void apply(input logic [1:0] idx, input logic [7:0] d);
		case (idx)
			2'h0: model.route = d;
			2'h1: begin
				model.gain  = d[7:4];
				model.clamp = {2'b00, ~d[3:2]};  // inputs 2 and 3 never clamped on the bus
				model.aux   = d[1:0];
			end
			2'h2: model.drive = d[3:0];
			default: ;                       // index three stores nothing
		endcase
	endfunction : apply

	function automatic logic [7:0] pin_routes(input logic [1:0] lv);
		logic [7:0] r;
		for (int j = 0; j < 4; j++) r[2*j +: 2] = 2'(j) ^ lv;
		return r;
	endfunction : pin_routes

	// ---------------------------------------------------------------
	// driver tasks
	// ---------------------------------------------------------------
	task automatic note();
		bfm.tick(4);
		notes.push_back(model);
		-> resultReady;
		bfm.tick(1);
	endtask : note

	task automatic do_reset(input logic [2:0] s);
		reset = 1'b1;
		strap = s;
		repeat (4) @(posedge clk);
		#1;
		reset = 1'b0;
		bfm.tick(8);     // straps settle at the fourth edge, outputs one later
	endtask : do_reset

	// one frame of nd data bytes; ok says whether the device should take it
	task automatic wr(input logic [7:0] adr, input logic [7:0] sub,
			input logic [31:0] data, input int nd, input logic ok);
		logic [5:0] acked;
		logic [1:0] idx;
		bfm.xfer({adr, sub, data}, nd + 2, acked);
		check("ack", acked, ok ? (6'h3f >> (4 - nd)) : 6'h00);
		idx = sub[1:0];
		for (int i = 0; i < nd; i++) begin
			if (ok) apply(idx, data[31-8*i -: 8]);
			idx = idx[1] ? 2'h0 : idx + 2'h1;
		end
		note();
	endtask : wr

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(14123));
		reset = 1'b1;
		strap = 3'($urandom % 7);
		good = {`VXC_ADDR_HIGH, strap, `VXC_RW_WRITE};
		do_reset(strap);
		model = '{route: 8'h00, gain: 4'h0, clamp: 4'h3, drive: 4'h0, aux: 2'h0};
		note();
		// enables first, random upper nibble must not matter
		wr(good, 8'h02, $urandom, 1, 1'b1);
		wr(good, 8'h00, 32'he4000000, 1, 1'b1);
		wr(good, 8'h01, 32'hff000000, 1, 1'b1);
		wr(good, 8'h00, $urandom, 4, 1'b1);
		wr(good ^ 8'h02, 8'h00, $urandom, 2, 1'b0);
		wr(good | 8'h01, 8'h01, $urandom, 1, 1'b0);
		wr(good, 8'h03, $urandom, 2, 1'b1);
		repeat (10) wr(good, 8'($urandom % 3), $urandom, 1 + $urandom % 4, 1'b1);
		// pin-controlled mode: idle lines read as both high
		do_reset(3'h7);
		model = '{route: pin_routes(2'h3), gain: 4'h0, clamp: 4'hf, drive: 4'hf, aux: 2'h0};
		note();
		wr({`VXC_ADDR_HIGH, 3'h7, `VXC_RW_WRITE}, 8'h02, 32'h0, 1, 1'b0);
		for (int v = 0; v < 4; v++) begin
			bfm.set_levels(2'(v));
			bfm.tick(6);
			model.route = pin_routes(2'(v));
			note();
		end
		give_verdict();
	end

	// watchdog: the run needs about 120 us, so 1 ms means a hang
	initial begin
		#1000000;
		failures++;
		give_verdict();
	end
endmodule : test_video_crosspoint_control
